// *** verilog/fam_pkg.sv ***
// constants, register map and field layouts for the flash address map block
package fam_pkg;
    // ----------------------------------------------------------------
    // cpu map windows
    // ----------------------------------------------------------------
    localparam logic [15:0] FAM_WIN_LO_BASE  = 16'h4000;
    localparam logic [15:0] FAM_WIN_PG_BASE  = 16'h8000;
    localparam logic [15:0] FAM_WIN_HI_BASE  = 16'hC000;
    localparam logic [1:0]  FAM_WIN_BOTTOM   = 2'h1;
    localparam logic [1:0]  FAM_WIN_PAGED    = 2'h2;
    localparam logic [1:0]  FAM_WIN_TOP      = 2'h3;
    localparam logic [7:0]  FAM_PAGE_BOTTOM  = 8'h3E;
    localparam logic [7:0]  FAM_PAGE_TOP     = 8'h3F;
    localparam logic [16:0] FAM_ARR_BOTTOM   = 17'h18000;
    localparam logic [16:0] FAM_ARR_TOP      = 17'h1C000;
    localparam logic [13:0] FAM_WIN_MASK     = 14'h3FFF;
    // array geometry: 512 rows of 64 bytes, sector of 8 rows
    localparam int          FAM_ROWS         = 512;
    localparam int          FAM_ROW_BYTES    = 64;
    localparam int          FAM_SECTOR_ROWS  = 8;
    localparam int          FAM_ROW_LSB      = 6;
    localparam int          FAM_SECTOR_LSB   = 9;
    // ----------------------------------------------------------------
    // configuration field
    // ----------------------------------------------------------------
    localparam logic [15:0] FAM_KEY_FIRST    = 16'hFF00;
    localparam logic [15:0] FAM_KEY_LAST     = 16'hFF07;
    localparam logic [15:0] FAM_PROT_BYTE    = 16'hFF0D;
    localparam logic [15:0] FAM_SEC_BYTE     = 16'hFF0F;
    // ----------------------------------------------------------------
    // region limits, indexed by the two size-select bits
    // ----------------------------------------------------------------
    localparam logic [13:0] FAM_LOW_END0     = 14'h03FF;
    localparam logic [13:0] FAM_LOW_END1     = 14'h07FF;
    localparam logic [13:0] FAM_LOW_END2     = 14'h0FFF;
    localparam logic [13:0] FAM_LOW_END3     = 14'h1FFF;
    localparam logic [13:0] FAM_HIGH_BEG0    = 14'h3800;
    localparam logic [13:0] FAM_HIGH_BEG1    = 14'h3000;
    localparam logic [13:0] FAM_HIGH_BEG2    = 14'h2000;
    localparam logic [13:0] FAM_HIGH_BEG3    = 14'h0000;
    // ----------------------------------------------------------------
    // register indices (word offsets of the module, paddr[5:2]), 16 registers
    // ----------------------------------------------------------------
    localparam logic [3:0]  FAM_REG_CLKDIV   = 4'h0;
    localparam logic [3:0]  FAM_REG_SEC      = 4'h1;
    localparam logic [3:0]  FAM_REG_RSVD1    = 4'h2;
    localparam logic [3:0]  FAM_REG_CFG      = 4'h3;
    localparam logic [3:0]  FAM_REG_PROT     = 4'h4;
    localparam logic [3:0]  FAM_REG_PAGE     = 4'h8;
    localparam logic [3:0]  FAM_REG_QADDR    = 4'h9;
    localparam logic [3:0]  FAM_REG_QRES     = 4'hA;
    localparam int          FAM_REG_COUNT    = 16;
    // ----------------------------------------------------------------
    // protection register fields, clkdiv and config write masks
    // ----------------------------------------------------------------
    localparam int          FAM_PROT_OPEN    = 7;
    localparam int          FAM_PROT_HDIS    = 5;
    localparam int          FAM_PROT_HS      = 3;
    localparam int          FAM_PROT_LDIS    = 2;
    localparam int          FAM_PROT_LS      = 0;
    localparam logic [7:0]  FAM_CLKDIV_WMASK = 8'h7F;
    localparam int          FAM_CLKDIV_LOAD  = 7;
    localparam logic [7:0]  FAM_CFG_WMASK    = 8'hE0;
    // query result fields
    localparam int          FAM_QR_HIT       = 0;
    localparam int          FAM_QR_VALID     = 1;
    localparam int          FAM_QR_KEY       = 2;
    localparam int          FAM_QR_CFGP      = 3;
    localparam int          FAM_QR_CFGS      = 4;
    localparam logic [7:0]  FAM_ZERO8        = 8'h00;
    localparam logic [31:0] FAM_ZERO32       = 32'h0000_0000;

    typedef enum logic [2:0] {
        FAM_IDLE   = 3'b001,
        FAM_ACCESS = 3'b010,
        FAM_DONE   = 3'b100
    } fam_apb_state_t;
endpackage

// *** verilog/fam_decode_if.sv ***
// carrier between the top and the address decoder
interface fam_decode_if;
    import fam_pkg::*;
    logic [15:0] cpuAddr;
    logic [7:0]  pageSel;
    logic [7:0]  protection;
    logic [1:0]  window;
    logic [16:0] arrayAddr;
    logic        lowHit;
    logic        highHit;
    logic        protHit;
    logic        keyHit;
    logic        cfgProtHit;
    logic        cfgSecHit;
    modport top (output cpuAddr, output pageSel, output protection, input window,
                 input arrayAddr, input lowHit, input highHit, input protHit,
                 input keyHit, input cfgProtHit, input cfgSecHit);
    modport dec (input cpuAddr, input pageSel, input protection, output window,
                 output arrayAddr, output lowHit, output highHit, output protHit,
                 output keyHit, output cfgProtHit, output cfgSecHit);
endinterface

// *** verilog/fam_decode.sv ***
// combinational window, page and protection-region decoder
module fam_decode
    import fam_pkg::*;
(
    fam_decode_if.dec dif
);
    // size-select decode for the low region; highBeg serves the high region
    function automatic logic [13:0] lowEnd(input logic [1:0] sel);
        unique case (sel)
            2'h0: lowEnd = FAM_LOW_END0;
            2'h1: lowEnd = FAM_LOW_END1;
            2'h2: lowEnd = FAM_LOW_END2;
            2'h3: lowEnd = FAM_LOW_END3;
        endcase
    endfunction

    function automatic logic [13:0] highBeg(input logic [1:0] sel);
        unique case (sel)
            2'h0: highBeg = FAM_HIGH_BEG0;
            2'h1: highBeg = FAM_HIGH_BEG1;
            2'h2: highBeg = FAM_HIGH_BEG2;
            2'h3: highBeg = FAM_HIGH_BEG3;
        endcase
    endfunction

    logic [13:0] offs;
    logic [7:0]  page;
    logic        isBottom;
    logic        isTop;

    // window select and physical page
    always_comb begin
        offs = dif.cpuAddr[13:0] & FAM_WIN_MASK;
        dif.window = (dif.cpuAddr >= FAM_WIN_LO_BASE) ? dif.cpuAddr[15:14] : 2'h0; // [R01]
        unique case (dif.window)
            FAM_WIN_BOTTOM: page = FAM_PAGE_BOTTOM;  // [R04]
            FAM_WIN_TOP:    page = FAM_PAGE_TOP;     // [R04]
            FAM_WIN_PAGED:  page = dif.pageSel;      // [R02]
            default:        page = FAM_ZERO8;
        endcase
        // paged aliases of 0x3E/0x3F fall out of the same page compare
        isBottom = (dif.window != 2'h0) && (page == FAM_PAGE_BOTTOM); // [R03]
        isTop    = (dif.window != 2'h0) && (page == FAM_PAGE_TOP);    // [R03]
        // 32K array: only the two top pages exist, others read unmapped
        dif.arrayAddr = isBottom ? (FAM_ARR_BOTTOM | {3'h0, offs}) :
                        isTop    ? (FAM_ARR_TOP | {3'h0, offs}) : 17'h0; // [R04] [R12]
        // regions are in-page offsets so aliases share the same limits
        dif.lowHit  = isBottom && !dif.protection[FAM_PROT_LDIS]
                      && (offs <= lowEnd(dif.protection[FAM_PROT_LS +: 2]));  // [R06] [R11]
        dif.highHit = isTop && !dif.protection[FAM_PROT_HDIS]
                      && (offs >= highBeg(dif.protection[FAM_PROT_HS +: 2])); // [R06] [R11]
        // open bit clear protects every array byte, low/high regions included
        dif.protHit = (isBottom || isTop) &&
                      (dif.lowHit || dif.highHit || !dif.protection[FAM_PROT_OPEN]); // [R05] [R07]
        // config field lives in the top page, so a paged alias hits it too
        dif.keyHit     = isTop && (offs >= FAM_KEY_FIRST[13:0])
                         && (offs <= FAM_KEY_LAST[13:0]); // [R08]
        dif.cfgProtHit = isTop && (offs == FAM_PROT_BYTE[13:0]); // [R09]
        dif.cfgSecHit  = isTop && (offs == FAM_SEC_BYTE[13:0]);  // [R09]
    end
endmodule

// *** verilog/fam_regs.sv ***
// sixteen byte-wide control and status registers
module fam_regs
    import fam_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       wrEn,
    input  wire logic [3:0] wrIdx,
    input  wire logic [7:0] wrData,
    input  wire logic [3:0] rdIdx,
    output logic      [7:0] rdData_ff,
    output logic      [7:0] protection,
    output logic      [7:0] pageSel
);
    logic [7:0] regs_ff     [FAM_REG_COUNT];
    logic [7:0] nxt_regs    [FAM_REG_COUNT];
    logic [7:0] nxt_rdData;

    // one generate slot per byte register, write lands on its own index
    for (genvar i = 0; i < FAM_REG_COUNT; i++) begin : g_reg
        always_comb begin
            nxt_regs[i] = regs_ff[i];
            if (wrEn && (wrIdx == 4'(i))) begin
                nxt_regs[i] = wrData; // [R10]
            end
        end
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                regs_ff[i] <= FAM_ZERO8;
            end else begin
                regs_ff[i] <= nxt_regs[i];
            end
        end
    end

    // registered read port, mux by index
    always_comb begin
        nxt_rdData = regs_ff[rdIdx]; // [R10]
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdData_ff <= FAM_ZERO8;
        end else begin
            rdData_ff <= nxt_rdData;
        end
    end

    assign protection = regs_ff[FAM_REG_PROT];
    assign pageSel    = regs_ff[FAM_REG_PAGE];
endmodule

// *** verilog/fam_flash_map.sv ***
// apb-reached address map and protection decode for the 32K flash array
// ----------------------------------------------------------------
// Overview of operation
// R01 - cpu addresses 0x4000..0xFFFF form three 16K flash windows
// R02 - window 0x8000..0xBFFF uses page_select to pick the physical page
// R03 - page_select 0x3E/0x3F aliases the fixed bottom/top page
// R04 - 0x4000 window is page 0x3E, 0xC000 window is page 0x3F
// R05 - protection open bit cleared protects the whole array at once
// R06 - low, high and remaining areas are each protectable
// R07 - low area may stay writable while the rest is protected (here open bit clear protects the low area too)
// R08 - config bytes 0xFF00..0xFF07 hold the backdoor key
// R09 - protection defaults at 0xFF0D, security at 0xFF0F
// R10 - sixteen byte registers at module offsets 0x0..0xF (here at word-aligned offsets 0x00..0x3C)
// R11 - low region ends 0x43FF..0x5FFF, high begins 0xF800..0xC000
// R12 - array is 512 rows of 64 bytes, eight-row sectors
// R13 - program or erase target in protected region flags a hit
// ----------------------------------------------------------------
//
// Decided for this implementation: the APB interface to the registers.
module fam_flash_map
    import fam_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] pgmAddr,
    input  wire logic        pgmReq,
    output logic             protHit_ff,
    output logic      [16:0] pgmArrayAddr_ff,
    output logic      [8:0]  pgmRow_ff,
    output logic      [5:0]  pgmSector_ff
);
    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    fam_apb_state_t state_ff;
    fam_apb_state_t nxt_state;
    logic [31:0]    prdata_ff;
    logic [31:0]    nxt_prdata;
    logic           pready_ff;
    logic           nxt_pready;
    logic           pslverr_ff;
    logic           nxt_pslverr;
    logic           mapped;
    logic [3:0]     regIdx;
    logic           regWr;
    logic [7:0]     regRd;
    logic [7:0]     protection;
    logic [7:0]     pageSel;
    logic [15:0]    qAddr_ff;
    logic [15:0]    nxt_qAddr;
    logic [7:0]     qRes_ff;
    logic [7:0]     nxt_qRes;
    logic [7:0]     wrByte;

    // only word-aligned offsets 0x00..0x3C decode; everything else errors
    always_comb begin
        regIdx = paddr[5:2];
        mapped = (paddr[31:6] == 26'h0) && (paddr[1:0] == 2'h0); // [R10]
        wrByte = pwdata[7:0];
    end

    // two-cycle answer: access phase is taken, answer lands next edge
    always_comb begin
        nxt_state   = state_ff;
        nxt_pready  = 1'b0;
        nxt_pslverr = 1'b0;
        nxt_prdata  = prdata_ff;
        regWr       = 1'b0;
        unique case (state_ff)
            FAM_IDLE: begin
                if (psel && penable) begin
                    nxt_state = FAM_ACCESS;
                end
            end
            FAM_ACCESS: begin
                nxt_state   = FAM_DONE;
                nxt_pready  = 1'b1;
                nxt_pslverr = !mapped;
                regWr       = mapped && pwrite && pstrb[0];
                if (!pwrite) begin
                    nxt_prdata = mapped ? {24'h0, regRd} : FAM_ZERO32;
                end
            end
            FAM_DONE: begin
                nxt_state = FAM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_ff   <= FAM_IDLE;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= FAM_ZERO32;
        end else begin
            state_ff   <= nxt_state;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff  <= nxt_prdata;
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    logic [7:0] rdByte_ff;
    logic [7:0] wrMasked;

    // security and reserved slots read zero; query slots are served from live state here
    always_comb begin
        unique case (regIdx)
            FAM_REG_SEC:   regRd = FAM_ZERO8;
            FAM_REG_RSVD1: regRd = FAM_ZERO8;
            FAM_REG_QADDR: regRd = qAddr_ff[7:0];
            FAM_REG_QRES:  regRd = qRes_ff;
            default:       regRd = rdByte_ff;
        endcase
        unique case (regIdx)
            FAM_REG_CLKDIV: wrMasked = (wrByte & FAM_CLKDIV_WMASK)
                                       | (8'h1 << FAM_CLKDIV_LOAD);
            FAM_REG_CFG:    wrMasked = wrByte & FAM_CFG_WMASK;
            default:        wrMasked = wrByte;
        endcase
    end

    fam_regs u_regs (
        .clk        (clk),
        .reset_n    (reset_n),
        .wrEn       (regWr && (regIdx != FAM_REG_SEC) && (regIdx != FAM_REG_RSVD1)),
        .wrIdx      (regIdx),
        .wrData     (wrMasked),
        .rdIdx      (regIdx),
        .rdData_ff  (rdByte_ff),
        .protection (protection),
        .pageSel    (pageSel)
    );

    // ----------------------------------------------------------------
    // software address query: qAddr write, qRes read
    // ----------------------------------------------------------------
    fam_decode_if qif ();
    fam_decode_if pif ();

    // query address takes both bytes when pstrb[1] is set, else only the low byte
    always_comb begin
        nxt_qAddr = qAddr_ff;
        if (regWr && (regIdx == FAM_REG_QADDR)) begin
            nxt_qAddr = pstrb[1] ? pwdata[15:0] : {qAddr_ff[15:8], wrByte};
        end
        nxt_qRes = FAM_ZERO8;
        nxt_qRes[FAM_QR_HIT]   = qif.protHit;                       // [R13]
        nxt_qRes[FAM_QR_VALID] = (qif.window != 2'h0);              // [R01]
        nxt_qRes[FAM_QR_KEY]   = qif.keyHit;                        // [R08]
        nxt_qRes[FAM_QR_CFGP]  = qif.cfgProtHit;                    // [R09]
        nxt_qRes[FAM_QR_CFGS]  = qif.cfgSecHit;                     // [R09]
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            qAddr_ff <= 16'h0;
            qRes_ff  <= FAM_ZERO8;
        end else begin
            qAddr_ff <= nxt_qAddr;
            qRes_ff  <= nxt_qRes;
        end
    end

    assign qif.cpuAddr    = qAddr_ff;
    assign qif.pageSel    = pageSel;
    assign qif.protection = protection;

    fam_decode u_qdec (
        .dif (qif.dec)
    );

    // ----------------------------------------------------------------
    // sequencer-side target check
    // ----------------------------------------------------------------
    logic        nxt_protHit;
    logic [16:0] nxt_pgmArrayAddr;
    logic [8:0]  nxt_pgmRow;
    logic [5:0]  nxt_pgmSector;

    assign pif.cpuAddr    = pgmAddr;
    assign pif.pageSel    = pageSel;
    assign pif.protection = protection;

    fam_decode u_pdec (
        .dif (pif.dec)
    );

    // a target outside the array counts as protected so it is rejected
    always_comb begin
        // no array address means below the windows or a page the array lacks
        nxt_protHit      = pgmReq && (pif.protHit || (pif.arrayAddr == 17'h0)); // [R13]
        nxt_pgmArrayAddr = pif.arrayAddr;                                  // [R02] [R04]
        nxt_pgmRow       = pif.arrayAddr[FAM_ROW_LSB +: 9];                 // [R12]
        nxt_pgmSector    = pif.arrayAddr[FAM_SECTOR_LSB +: 6];              // [R12]
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            protHit_ff      <= 1'b0;
            pgmArrayAddr_ff <= 17'h0;
            pgmRow_ff       <= 9'h0;
            pgmSector_ff    <= 6'h0;
        end else begin
            protHit_ff      <= nxt_protHit;
            pgmArrayAddr_ff <= nxt_pgmArrayAddr;
            pgmRow_ff       <= nxt_pgmRow;
            pgmSector_ff    <= nxt_pgmSector;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    fixed_bottom_a: assert property (@(posedge clk) disable iff (!reset_n) // [R04]
        (pgmAddr[15:14] == FAM_WIN_BOTTOM) |=>
        (pgmArrayAddr_ff[16:14] == FAM_ARR_BOTTOM[16:14]))
        else $error("bottom window not mapped to bottom page");
    fixed_top_a: assert property (@(posedge clk) disable iff (!reset_n) // [R04]
        (pgmAddr[15:14] == FAM_WIN_TOP) |=> (pgmArrayAddr_ff[16:14] == FAM_ARR_TOP[16:14]))
        else $error("top window not mapped to top page");
    paged_alias_a: assert property (@(posedge clk) disable iff (!reset_n) // [R03]
        (pgmAddr[15:14] == FAM_WIN_PAGED && pageSel == FAM_PAGE_TOP) |=>
        (pgmArrayAddr_ff[16:14] == FAM_ARR_TOP[16:14]))
        else $error("paged alias of top page wrong");
    global_prot_a: assert property (@(posedge clk) disable iff (!reset_n) // [R05]
        (pgmReq && !protection[FAM_PROT_OPEN]) |=> protHit_ff)
        else $error("global protection did not block target");
    low_open_a: assert property (@(posedge clk) disable iff (!reset_n) // [R07]
        (pgmReq && pgmAddr == FAM_WIN_LO_BASE && protection[FAM_PROT_LDIS]
         && protection[FAM_PROT_OPEN]) |=> !protHit_ff)
        else $error("open low area flagged as protected");
    unmapped_a: assert property (@(posedge clk) disable iff (!reset_n) // [R01]
        (pgmReq && pgmAddr < FAM_WIN_LO_BASE) |=> protHit_ff)
        else $error("target below flash window accepted");
    apb_ready_a: assert property (@(posedge clk) disable iff (!reset_n) // [R10]
        (psel && penable && state_ff == FAM_IDLE) |=> ##1 pready_ff)
        else $error("apb answer not two cycles after access");
    no_hit_idle_a: assert property (@(posedge clk) disable iff (!reset_n) // [R13]
        !pgmReq |=> !protHit_ff)
        else $error("protected hit without request");
endmodule

// *** tb/fam_cpu_model.sv ***
// cpu-side register bus master model for the flash address map
module fam_cpu_model (
    input  wire logic        clk,
    input  wire logic        pready,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [31:0] paddr,
    output logic      [31:0] pwdata,
    output logic      [3:0]  pstrb
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // bus transfers
    // ----------------------------------------------------------------
    // idle bus from time zero, so no block input floats
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    end

    // setup, then access held until pready is seen high at an edge
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        input logic [3:0] s);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        // released address and data go inverse so stale values never pass as valid
        {psel, penable} <= 2'b00;
        paddr  <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// *** tb/tb.sv ***
// self-checking bench for the flash address map and protection decode
module tb
    import fam_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // signals, design and bus master
    // ----------------------------------------------------------------
    logic        clk, psel, penable, pwrite, pready, pslverr, protHit;
    logic        reset_n = 1'b0;
    logic        pgmReq = 1'b0;
    logic        reqDly_ff = 1'b0;
    logic [15:0] pgmAddr = 16'h0000;
    logic [7:0]  protNow = 8'h00;
    logic [7:0]  pageNow = 8'h00;
    logic [31:0] paddr, pwdata, prdata;
    logic [3:0]  pstrb;
    logic [16:0] pgmArray;
    logic [8:0]  pgmRow;
    logic [5:0]  pgmSector;
    logic [13:0] loEnd, hiBeg;
    logic [33:0] apbQ[$];
    logic [17:0] pgmQ[$];
    logic [33:0] apbE;
    logic [17:0] pgmE;
    int          mismatches = 0;
    int          testsRun = 0;
    int          cycles = 0;

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    fam_flash_map uut (
        .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pgmAddr(pgmAddr), .pgmReq(pgmReq), .protHit_ff(protHit),
        .pgmArrayAddr_ff(pgmArray), .pgmRow_ff(pgmRow), .pgmSector_ff(pgmSector));
    fam_cpu_model cpu (.clk(clk), .pready(pready), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));

    // ----------------------------------------------------------------
    // expectations, drivers and checks
    // ----------------------------------------------------------------
    // region limit for a size code: low end, or high begin when hi set
    function automatic logic [13:0] lim(input logic [1:0] s, input logic hi);
        case (s)
            2'h0: lim = hi ? FAM_HIGH_BEG0 : FAM_LOW_END0;
            2'h1: lim = hi ? FAM_HIGH_BEG1 : FAM_LOW_END1;
            2'h2: lim = hi ? FAM_HIGH_BEG2 : FAM_LOW_END2;
            default: lim = hi ? FAM_HIGH_BEG3 : FAM_LOW_END3;
        endcase
    endfunction

    // {sec byte, prot byte, key, in window, hit, array address}
    function automatic logic [21:0] expectMap(input logic [15:0] a);
        logic [13:0] off;
        logic        bot, top, hit;
        logic [16:0] arr;
        off = a[13:0];
        bot = a[15:14] == FAM_WIN_BOTTOM || (a[15:14] == FAM_WIN_PAGED && pageNow == 8'h3E);
        top = a[15:14] == FAM_WIN_TOP || (a[15:14] == FAM_WIN_PAGED && pageNow == 8'h3F);
        hit = !(bot || top) || !protNow[FAM_PROT_OPEN]
            || (bot && !protNow[FAM_PROT_LDIS] && off <= lim(protNow[1:0], 1'b0))
            || (top && !protNow[FAM_PROT_HDIS] && off >= lim(protNow[4:3], 1'b1));
        arr = bot ? FAM_ARR_BOTTOM + 17'(off) : (top ? FAM_ARR_TOP + 17'(off) : 17'h0);
        expectMap = {top && off == FAM_SEC_BYTE[13:0], top && off == FAM_PROT_BYTE[13:0],
            top && off >= FAM_KEY_FIRST[13:0] && off <= FAM_KEY_LAST[13:0], a[15:14] != 2'h0,
            hit, arr};
    endfunction

    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic summarize();
        if (mismatches == 0 && testsRun > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // notes {is read, error, data} then runs the transfer
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       input logic err, input logic [31:0] ex);
        apbQ.push_back({!wr, err, ex});
        cpu.xfer(wr, a, d, 4'h3);
    endtask

    // target check for one cycle, then the same address through the query registers
    task automatic probe(input logic [15:0] a);
        logic [21:0] e;
        e = expectMap(a);
        pgmQ.push_back(e[17:0]);
        @(posedge clk);
        pgmAddr <= a;
        pgmReq  <= 1'b1;
        @(posedge clk);
        pgmReq  <= 1'b0;
        pgmAddr <= ~a;
        apb(1'b1, 32'h24, {16'h0, a}, 1'b0, 32'h0);
        // query hit flags only protected array bytes, not unmapped places
        apb(1'b0, 32'h28, 32'h0, 1'b0, {27'h0, e[21:18], e[17] && (e[16:0] != 17'h0)});
    endtask

    // results checked mid-cycle, once registered outputs have settled
    always @(negedge clk) begin
        if (pready) begin
            apbE = apbQ.pop_front();
            check("pslverr", 32'(pslverr), 32'(apbE[32]));
            if (apbE[33]) check("prdata", prdata, apbE[31:0]);
        end
        if (reqDly_ff) begin
            pgmE = pgmQ.pop_front();
            check("protHit", 32'(protHit), 32'(pgmE[17]));
            check("arrayAddr", 32'(pgmArray), 32'(pgmE[16:0]));
            check("row", 32'(pgmRow), 32'(pgmE[14:6]));
            check("sector", 32'(pgmSector), 32'(pgmE[14:9]));
        end
    end

    // hang guard, about three times the expected run
    always @(posedge clk) begin
        reqDly_ff <= pgmReq;
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches++;
            summarize();
        end
    end

    initial begin
        void'($urandom(32'h4f5d));
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        // reset values, ignored writes, unmapped and unaligned places
        apb(1'b0, 32'h10, 32'h0, 1'b0, 32'h0);
        apb(1'b0, 32'h20, 32'h0, 1'b0, 32'h0);
        apb(1'b1, 32'h04, 32'hFF, 1'b0, 32'h0);
        apb(1'b0, 32'h04, 32'h0, 1'b0, 32'h0);
        apb(1'b0, 32'h08, 32'h0, 1'b0, 32'h0);
        apb(1'b1, 32'h00, 32'h55, 1'b0, 32'h0);
        apb(1'b0, 32'h00, 32'h0, 1'b0, 32'hD5);
        apb(1'b0, 32'h40, 32'h0, 1'b1, 32'h0);
        apb(1'b1, 32'h13, 32'h1, 1'b1, 32'h0);
        probe(16'h4000);
        // every size code first, then random settings; pages cycle 0x3E, 0x3F, random throughout
        for (int i = 0; i < 40; i++) begin
            protNow = (i < 8) ? {i[2], 2'h0, i[1:0], 1'b0, i[1:0]} : 8'($urandom);
            pageNow = (i % 3 == 0) ? 8'h3E : ((i % 3 == 1) ? 8'h3F : 8'($urandom));
            apb(1'b1, 32'h10, {24'h0, protNow}, 1'b0, 32'h0);
            apb(1'b1, 32'h20, {24'h0, pageNow}, 1'b0, 32'h0);
            apb(1'b0, 32'h20, 32'h0, 1'b0, {24'h0, pageNow});
            loEnd = lim(protNow[1:0], 1'b0);
            hiBeg = lim(protNow[4:3], 1'b1);
            probe(FAM_WIN_LO_BASE);
            for (int w = 0; w < 4; w++) begin
                probe({w[1:0], loEnd});
                probe({w[1:0], loEnd + 14'h1});
                probe({w[1:0], hiBeg - 14'h1});
                probe({w[1:0], hiBeg});
                probe({w[1:0], 10'h3F0, 4'($urandom)});
                probe(16'($urandom));
            end
        end
        summarize();
    end
endmodule
